/* File: sim/eiec_bench.sv */
// Bench for the edge capture block
`timescale 1ns/1ps
module eiec_bench;
    logic mclk_in = 1'h0, resetn_in = 1'h0, ext_sel_in = 1'h0;
    logic [2:0] fire = 3'h0;
    wire port0_bit7_in, port2_bit2_in, nmi_in, output_clock_out;
    wire [2:0] pending_out, level_out, req_out;
    eiec_pkg::eiec_sw_t sw_in = '0;
    // Rows: fire pins, select, expected pending
    logic [6:0] rows [5] = '{7'h11, 7'h22, 7'h2B, 7'h44, 7'h18};
    int errors = 0, checks = 0;
    always #50 mclk_in = ~mclk_in;
    eiec_source src (.mclk_in, .fire_in(fire), .ack_in(sw_in.ack), .pins_out({nmi_in, port2_bit2_in, port0_bit7_in}));
    eiec_top dut (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .port0_bit7_in(port0_bit7_in),
        .port2_bit2_in(port2_bit2_in),
        .nmi_in(nmi_in),
        .ext_sel_in(ext_sel_in),
        .sw_in(sw_in),
        .output_clock_out(output_clock_out),
        .pending_out(pending_out),
        .level_out(level_out),
        .req_out(req_out)
    );
    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        checks++;
        errors += int'(seen !== exp);
        if (seen !== exp) $display("ERROR %0t pending mismatch", $time);
    endtask
    task automatic wrap_up;
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (800) @(negedge mclk_in);
        errors++;
        wrap_up();
    end
    initial begin
        repeat (20) @(negedge mclk_in);
        chk(pending_out | req_out, 3'h0);
        resetn_in = 1'h1;
        foreach (rows[i]) begin
            {fire, ext_sel_in} = rows[i][6:3];
            repeat (12) @(negedge mclk_in);
            chk(pending_out, rows[i][2:0]);
            {fire, sw_in.ack} = 6'h07;
            @(negedge mclk_in);
            sw_in.ack = 3'h0;
            repeat (8) @(negedge mclk_in);
            chk(pending_out, 3'h0);
        end
        sw_in = 9'h120;
        @(negedge mclk_in);
        sw_in = '0;
        @(negedge mclk_in);
        chk(pending_out, 3'h4);
        // Reset in mid-run clears everything, then an edge still lands
        resetn_in = 1'h0;
        @(negedge mclk_in);
        chk(pending_out | level_out | req_out | {2'h0, output_clock_out}, 3'h0);
        resetn_in = 1'h1;
        {fire, ext_sel_in} = 4'h2;
        repeat (12) @(negedge mclk_in);
        chk(pending_out, 3'h1);
        // Software write of zero clears while the pin is still held high
        sw_in = 9'h040;
        @(negedge mclk_in);
        sw_in = '0;
        @(negedge mclk_in);
        chk(pending_out, 3'h0);
        wrap_up();
    end
endmodule

/* File: sim/eiec_monitor.sv */
// Checker of request, pending and output clock timing
`timescale 1ns/1ps
module eiec_monitor (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Pins and select
    input wire logic port0_bit7_in,
    input wire logic port2_bit2_in,
    input wire logic ext_sel_in,
    // Software access
    input wire eiec_pkg::eiec_sw_t sw_in,
    // Outputs
    input wire logic output_clock_out,
    input wire logic [2:0] pending_out,
    input wire logic [2:0] level_out,
    input wire logic [2:0] req_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    a_req_width: assert property ($rose(req_out[0]) |=> req_out[0] ##1 !req_out[0])
        else $error("bad request width");
    a_req_pend: assert property ($rose(req_out[1]) |-> pending_out[1]) else $error("pending not set");
    a_req_phase: assert property ($rose(req_out[2]) |-> $past(output_clock_out)) else $error("phase");
    a_sel_src: assert property ($rose(level_out[0]) |-> $past(ext_sel_in ? port2_bit2_in : port0_bit7_in, 2))
        else $error("wrong source pin");
    a_sw_set: assert property (sw_in.wr[2] && sw_in.wdata[2] |=> pending_out[2]) else $error("write lost");
    a_pend_hold: assert property (pending_out[0] && !sw_in.ack[0] && !sw_in.wr[0] |=> pending_out[0])
        else $error("pending dropped");
    a_no_spur: assert property ($rose(pending_out[2]) |-> req_out[2] || $past(sw_in.wr[2]))
        else $error("pending without cause");
    a_clk_high: assert property (output_clock_out |=> !output_clock_out)
        else $error("output clock high too long");
    c_ext: cover property ($rose(pending_out[0]));
    c_both: cover property (pending_out[1:0] == 2'h3);
    c_write: cover property (sw_in.wr[2]);
endmodule
bind eiec_top eiec_monitor mon (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .port0_bit7_in(port0_bit7_in),
    .port2_bit2_in(port2_bit2_in),
    .ext_sel_in(ext_sel_in),
    .sw_in(sw_in),
    .output_clock_out(output_clock_out),
    .pending_out(pending_out),
    .level_out(level_out),
    .req_out(req_out)
);

/* File: sim/eiec_source.sv */
// Partner: interrupt source holding each pin high until acknowledged
`timescale 1ns/1ps
module eiec_source (
    // Clock
    input wire logic mclk_in,
    // Commands
    input wire logic [2:0] fire_in,
    input wire logic [2:0] ack_in,
    // Pins
    output logic [2:0] pins_out = 3'h0
);
    // Held level lets software recover an edge that was missed
    always @(posedge mclk_in) pins_out <= (pins_out | fire_in) & ~ack_in;
endmodule

/* File: verilog/eiec_edge_unit.sv */
// One source: output-clock-rising-edge register and one-state-time rising edge pulse
`timescale 1ns/1ps
module eiec_edge_unit (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Phase strobe
    input wire logic rise_en_in,
    // Synchronised source level
    input wire logic level_in,
    // Request pulse, one state time
    output logic req_out,
    output logic level_out
);
    import eiec_pkg::*;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            level_out <= 1'h0;
        end else if (rise_en_in) begin
            // Sampling only at the rising phase keeps changes away from the falling edge
            level_out <= level_in;
        end
    end
    // Request held for a whole state time, so it is never shortened
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_out <= 1'h0;
        end else if (rise_en_in) begin
            req_out <= level_in & ~level_out;
        end
    end
endmodule

/* File: verilog/eiec_pkg.sv */
// Package: constants and carrier types for the external interrupt edge capture block
// Behaviour
// - Qualifying edge gives one-state-time request pulse
// - Edge request sets that source's pending bit
// - Request width meets minimum regardless of phase
// - Inputs registered on output clock rising edge
// - First input port0_bit7 or port2_bit2 by select, second port2_bit2, third nmi
// - Software may write pending bits directly
package eiec_pkg;
    // Source indices
    localparam int EIEC_NSRC = 3;
    localparam int EIEC_SRC_EXT = 0;
    localparam int EIEC_SRC_SECOND = 1;
    localparam int EIEC_SRC_NMI = 2;
    // State time as a count of core clocks; output clock rises at phase zero
    localparam int EIEC_STATE_CYC = 2;
    localparam logic [0:0] EIEC_PH_RISE = 1'h0;
    localparam logic [0:0] EIEC_PH_LAST = 1'h1;
    localparam logic [EIEC_NSRC-1:0] EIEC_PEND_RST = 3'h0;
    localparam logic EIEC_SEL_PORT0 = 1'h0;

    typedef struct packed {
        logic [EIEC_NSRC-1:0] wr;
        logic [EIEC_NSRC-1:0] wdata;
        logic [EIEC_NSRC-1:0] ack;
    } eiec_sw_t;
endpackage

/* File: verilog/eiec_top.sv */
// Top: external interrupt edge capture with pending bits and output clock
`timescale 1ns/1ps
module eiec_top (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Pins
    input wire logic port0_bit7_in,
    input wire logic port2_bit2_in,
    input wire logic nmi_in,
    // Source select for the edge-triggered external interrupt
    input wire logic ext_sel_in,
    // Software access
    input wire eiec_pkg::eiec_sw_t sw_in,
    // Outputs
    output logic output_clock_out,
    output logic [eiec_pkg::EIEC_NSRC-1:0] pending_out,
    output logic [eiec_pkg::EIEC_NSRC-1:0] level_out,
    output logic [eiec_pkg::EIEC_NSRC-1:0] req_out
);
    import eiec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [0:0] phase;
    logic rise_en;
    logic [EIEC_NSRC-1:0] raw;
    logic [EIEC_NSRC-1:0] sync1;
    logic [EIEC_NSRC-1:0] sync2;
    logic [EIEC_NSRC-1:0] req;
    logic [EIEC_NSRC-1:0] lvl;
    logic [EIEC_NSRC-1:0] next_pending;

    // Divider: output clock high in the first half of each state time
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            phase <= EIEC_PH_RISE;
            output_clock_out <= 1'h0;
        end else begin
            phase <= (phase == EIEC_PH_LAST) ? EIEC_PH_RISE : phase + 1'h1;
            output_clock_out <= (phase == EIEC_PH_LAST);
        end
    end
    assign rise_en = (phase == EIEC_PH_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Source routing; the second input shares port2_bit2 with the alternative
    always_comb begin
        raw = '0;
        raw[EIEC_SRC_EXT] = (ext_sel_in == EIEC_SEL_PORT0) ? port0_bit7_in : port2_bit2_in;
        raw[EIEC_SRC_SECOND] = port2_bit2_in;
        raw[EIEC_SRC_NMI] = nmi_in;
    end

    // Pins are asynchronous: the routing mux feeds two flip-flops before the edge units read them
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    generate
        for (genvar i = 0; i < EIEC_NSRC; i++) begin : g_src
            eiec_edge_unit u_edge (
                .mclk_in(mclk_in),
                .resetn_in(resetn_in),
                .rise_en_in(rise_en),
                .level_in(sync2[i]),
                .req_out(req[i]),
                .level_out(lvl[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pending: a request wins over a same-cycle clear or acknowledge
    always_comb begin
        next_pending = pending_out;
        next_pending = next_pending & ~sw_in.ack;
        for (int i = 0; i < EIEC_NSRC; i++) begin
            if (sw_in.wr[i]) begin
                next_pending[i] = sw_in.wdata[i];
            end
        end
        // Repeat edges while set pulse req again but just leave it set
        next_pending = next_pending | req;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pending_out <= EIEC_PEND_RST;
        end else begin
            pending_out <= next_pending;
        end
    end

    // Levels let a recovery handler see a held-high input with no pending bit
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            level_out <= '0;
            req_out <= '0;
        end else begin
            level_out <= lvl;
            req_out <= req;
        end
    end
endmodule
